//--- core/wye_delta_pkg.sv
// Purpose: Shared constants for the wye-delta start sequencer
// Assumes: 32-bit AXI4-Lite register bus, 250 MHz clock
// Notes:   Timer settings are counted in time-base ticks of 1 ms
package wye_delta_pkg;

  // ****************************************
  // Clock and time base
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Bus widths
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CUR_W  = 16;
  localparam int unsigned TIME_W = 16;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] AT_SPEED_OFS  = 8'h04;
  localparam logic [7:0] FB_TIME_OFS   = 8'h08;
  localparam logic [7:0] RATED_CUR_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS    = 8'h10;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_WYE_BIT     = 0;
  localparam int unsigned CTRL_CONFIRM_BIT = 1;
  localparam int unsigned CTRL_CLOSED_BIT  = 2;
  localparam int unsigned STAT_FAULT_BIT   = 4;
  localparam int unsigned STAT_CONF_BIT    = 5;
  localparam logic [2:0]            CTRL_RST      = 3'h0;
  localparam logic [TIME_W-1:0]     AT_SPEED_RST  = 16'h2710;
  localparam logic [TIME_W-1:0]     FB_TIME_RST   = 16'h01f4;
  localparam logic [CUR_W-1:0]      RATED_CUR_RST = 16'h0064;

  // ****************************************
  // Transition thresholds: 85 % = 17/20, 25 % = 1/4
  // ****************************************
  localparam logic [20:0] CUR_NUM = 21'h000011;
  localparam logic [20:0] CUR_DEN = 21'h000014;

  // ****************************************
  // Response codes and states
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_WYE, ST_DELTA} seq_state_e;

endpackage

//--- core/wye_delta_start_sequencer.sv
// Purpose: Wye-delta electromechanical starter sequencer with AXI4-Lite registers
// Assumes: All inputs synchronous to aclk; fault_in is the summed protection trip
// Notes on behaviour
// - Sequencing starts only when wye-delta selected
// - Protections active except thyristor and stack overload
// - Early transition: current below 85%, 25% elapsed
// - Forced transition when full at-speed time ends
// - Start command energizes run relay, wye mode
// - Wye held until stop, timeout, early, fault
// - Delta: run and at-speed relays both energized
// - Closed transition uses delta feedback confirmation
// - Delta held until stop, fault or missing delta feedback
// - Open and closed transition both supported
// - Wye-delta keeps thyristor gates off, no ramps
// - Missing delta feedback in time trips fault
`timescale 1ns/1ps
module wye_delta_start_sequencer
  import wye_delta_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire  logic                            aclk,
  input  wire  logic                            aresetn,
  // AXI4-Lite write
  input  wire  logic [wye_delta_pkg::ADDR_W-1:0] awaddr,
  input  wire  logic                            awvalid,
  output logic                                  awready,
  input  wire  logic [wye_delta_pkg::DATA_W-1:0] wdata,
  input  wire  logic [3:0]                      wstrb,
  input  wire  logic                            wvalid,
  output logic                                  wready,
  output logic [1:0]                            bresp,
  output logic                                  bvalid,
  input  wire  logic                            bready,
  // AXI4-Lite read
  input  wire  logic [wye_delta_pkg::ADDR_W-1:0] araddr,
  input  wire  logic                            arvalid,
  output logic                                  arready,
  output logic [wye_delta_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                            rresp,
  output logic                                  rvalid,
  input  wire  logic                            rready,
  // Motor and controller status
  input  wire  logic                            start_cmd,
  input  wire  logic                            fault_in,
  input  wire  logic [wye_delta_pkg::CUR_W-1:0] motor_current,
  input  wire  logic                            delta_close_feedback_input,
  input  wire  logic                            soft_gate_req,
  // Relay, gate and protection outputs
  output logic                                  run_relay,
  output logic                                  at_speed_relay,
  output logic                                  scr_gate_en,
  output logic                                  thyristor_check_en,
  output logic                                  stack_overload_en,
  output logic                                  confirm_trip
);
  import wye_delta_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [2:0]        ctrl;
  logic [TIME_W-1:0] at_speed_time;
  logic [TIME_W-1:0] fb_time;
  logic [CUR_W-1:0]  rated_motor_current;
  logic              confirm_fault;
  logic              fb_seen;
  logic [31:0]       tick_cnt;
  logic              tick;
  logic [TIME_W-1:0] elapsed;
  seq_state_e        state;
  seq_state_e        next_state;
  logic              wr_hit;
  logic              cfg_wye;
  logic              cfg_confirm;
  logic              early_ok;
  logic              time_out;
  logic              fb_late;
  logic [20:0]       cur_scaled;
  logic [20:0]       rated_scaled;
  logic [31:0]       rd_word;
  logic              rd_map;
  logic              wr_map;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign cfg_wye     = ctrl[CTRL_WYE_BIT];
  assign cfg_confirm = ctrl[CTRL_CONFIRM_BIT] & ctrl[CTRL_CLOSED_BIT];
  assign wr_hit      = awvalid & awready;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data are taken together so no half write is ever pending
  always_comb begin
    case (awaddr)
      CTRL_OFS, AT_SPEED_OFS, FB_TIME_OFS, RATED_CUR_OFS, STATUS_OFS: wr_map = 1'b1;
      default: wr_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && wvalid && !awready && !bvalid) begin
        awready <= 1'b1;
        wready  <= 1'b1;
      end else begin
        awready <= 1'b0;
        wready  <= 1'b0;
      end
      if (wr_hit) begin
        bvalid <= 1'b1;
        bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl                <= CTRL_RST;
      at_speed_time       <= AT_SPEED_RST;
      fb_time             <= FB_TIME_RST;
      rated_motor_current <= RATED_CUR_RST;
    end else if (wr_hit) begin
      case (awaddr)
        CTRL_OFS:      ctrl <= 3'(merge({29'h0, ctrl}, wdata, wstrb));
        AT_SPEED_OFS:  at_speed_time <= 16'(merge({16'h0, at_speed_time}, wdata, wstrb));
        FB_TIME_OFS:   fb_time <= 16'(merge({16'h0, fb_time}, wdata, wstrb));
        RATED_CUR_OFS: rated_motor_current <= 16'(merge({16'h0, rated_motor_current}, wdata,
                                                        wstrb));
        default: ;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_comb begin
    rd_map  = 1'b1;
    rd_word = 32'h0;
    case (araddr)
      CTRL_OFS:      rd_word = {29'h0, ctrl};
      AT_SPEED_OFS:  rd_word = {16'h0, at_speed_time};
      FB_TIME_OFS:   rd_word = {16'h0, fb_time};
      RATED_CUR_OFS: rd_word = {16'h0, rated_motor_current};
      STATUS_OFS:    rd_word = {26'h0, confirm_fault, fault_in, fb_seen, at_speed_relay,
                                run_relay, state == ST_DELTA};
      default:       rd_map  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Time base
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYC - 1) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // Phase timer restarts on every state change; saturates instead of wrapping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed <= '0;
    end else if (next_state != state) begin
      elapsed <= '0;
    end else if (tick && elapsed != 16'hffff) begin
      elapsed <= elapsed + 16'h1;
    end
  end

  // ****************************************
  // Transition conditions
  // ****************************************
  assign cur_scaled   = {5'h0, motor_current} * CUR_DEN;
  assign rated_scaled = {5'h0, rated_motor_current} * CUR_NUM;
  assign early_ok = (cur_scaled < rated_scaled) &&
                    ({elapsed, 2'b00} > {2'b00, at_speed_time});
  assign time_out = elapsed >= at_speed_time;
  assign fb_late  = cfg_confirm && !fb_seen && (elapsed >= fb_time);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cfg_wye && start_cmd && !fault_in && !confirm_fault) begin
          next_state = ST_WYE;
        end
      end
      ST_WYE: begin
        // Leave wye on stop or fault
        if (!start_cmd || fault_in) begin
          next_state = ST_IDLE;
        end else if (time_out || early_ok) begin
          next_state = ST_DELTA;
        end
      end
      ST_DELTA: begin
        // Delta held until stop, fault or late delta feedback
        if (!start_cmd || fault_in || fb_late) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_relay      <= 1'b0;
      at_speed_relay <= 1'b0;
    end else begin
      run_relay      <= next_state != ST_IDLE;
      at_speed_relay <= next_state == ST_DELTA;
    end
  end

  // Feedback only checked on closed transition
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_seen <= 1'b0;
    end else if (state != ST_DELTA) begin
      fb_seen <= 1'b0;
    end else if (delta_close_feedback_input) begin
      fb_seen <= 1'b1;
    end
  end

  // Sticky trip; a new trip wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      confirm_fault <= 1'b0;
      confirm_trip  <= 1'b0;
    end else begin
      if (state == ST_DELTA && fb_late) begin
        confirm_fault <= 1'b1;
      end else if (wr_hit && awaddr == STATUS_OFS && wstrb[0] && wdata[STAT_CONF_BIT]) begin
        confirm_fault <= 1'b0;
      end
      confirm_trip <= (state == ST_DELTA && fb_late) ||
                      (confirm_fault && !(wr_hit && awaddr == STATUS_OFS && wstrb[0] &&
                                          wdata[STAT_CONF_BIT]));
    end
  end

  // Gates and two protections off in wye mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scr_gate_en        <= 1'b0;
      thyristor_check_en <= 1'b0;
      stack_overload_en  <= 1'b0;
    end else begin
      scr_gate_en        <= soft_gate_req && !cfg_wye;
      thyristor_check_en <= !cfg_wye;
      stack_overload_en  <= !cfg_wye;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  mode_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_IDLE && !cfg_wye) |=> state == ST_IDLE)
    else $error("sequence left idle without wye-delta mode");

  protect_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_wye |=> (!thyristor_check_en && !stack_overload_en))
    else $error("excluded protection still enabled");

  early_move_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_WYE && start_cmd && !fault_in && early_ok) |=> state == ST_DELTA)
    else $error("early transition missed");

  forced_move_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_WYE && start_cmd && !fault_in && time_out) |=>
      (state == ST_DELTA && at_speed_relay))
    else $error("forced transition missed");

  wye_relays_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_IDLE && next_state == ST_WYE) |=> (state == ST_WYE && run_relay && !at_speed_relay))
    else $error("wye relays wrong after start");

  stop_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != ST_IDLE && (!start_cmd || fault_in)) |=> (!run_relay && !at_speed_relay))
    else $error("relays still on after stop or fault");

  delta_relays_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_DELTA) |-> (run_relay && at_speed_relay))
    else $error("delta relays not both on");

  gate_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_wye |=> !scr_gate_en)
    else $error("gate enabled in wye-delta mode");

  confirm_trip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_DELTA && fb_late) |=> (confirm_fault && state == ST_IDLE) ##1 !run_relay)
    else $error("missing feedback did not trip");

  idle_relays_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == ST_IDLE && $past(state) == ST_IDLE) |-> (!run_relay && !at_speed_relay))
    else $error("relay on while idle");

endmodule

//--- testbench/contactor_model.sv
// Purpose: Contactor chain driven by the run and at-speed relays
// Assumes: Every contactor pulls in dly cycles after its coil (dly >= 1)
// Notes:   broken keeps the delta contactor open to provoke a trip
`timescale 1ns/1ps
module contactor_model (
  // Clock
  input  wire logic       aclk,
  // Relay coils
  input  wire logic       run_relay,
  input  wire logic       at_speed_relay,
  // Test controls
  input  wire logic [3:0] dly,
  input  wire logic       broken,
  // Feedback
  output logic            delta_close_feedback_input
);
  // ****************************************
  // Contactors: 0 wye, 1 main, 2 resistor, 3 delta
  // ****************************************
  logic [3:0] coil;
  logic [3:0] on;
  logic [3:0] cnt [4];
  assign coil[0] = run_relay && !on[2];
  assign coil[1] = run_relay && (on[0] || on[1]);
  assign coil[2] = at_speed_relay;
  assign coil[3] = at_speed_relay && !on[0] && !broken;
  // Drop lags one cycle; avoids a loop through the main seal-in
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= !coil[i] ? 4'h0 : (cnt[i] == dly) ? cnt[i] : cnt[i] + 4'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      on[i] = (cnt[i] == dly);
    end
  end
  // Closed delta reports back, open reads low
  assign delta_close_feedback_input = on[3];
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the wye-delta start sequencer
// Assumes: Time base cut to 4 cycles a tick, up-to-speed time 40 ticks
// Notes:   Inputs move on rising edges, outputs are read on falling edges
`timescale 1ns/1ps
module tb_top;
  import wye_delta_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        start_cmd = 1'b0;
  logic        fault_in = 1'b0;
  logic        soft_gate_req = 1'b1;
  logic        broken = 1'b0;
  logic [15:0] motor_current = 16'h0064;
  logic [3:0]  dly = 4'h1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        run_relay, at_speed_relay, scr_gate_en, confirm_trip;
  logic        thyristor_check_en, stack_overload_en, delta_close_feedback_input;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  int          n_errors = 0;
  int          checks_done = 0;

  always #2 aclk = ~aclk;

  wye_delta_start_sequencer #(.TICK_CYC(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .start_cmd(start_cmd), .fault_in(fault_in),
    .motor_current(motor_current), .delta_close_feedback_input(delta_close_feedback_input),
    .soft_gate_req(soft_gate_req), .run_relay(run_relay), .at_speed_relay(at_speed_relay),
    .scr_gate_en(scr_gate_en), .thyristor_check_en(thyristor_check_en),
    .stack_overload_en(stack_overload_en), .confirm_trip(confirm_trip));
  contactor_model u_cont (.aclk(aclk), .run_relay(run_relay),
    .at_speed_relay(at_speed_relay), .dly(dly), .broken(broken),
    .delta_close_feedback_input(delta_close_feedback_input));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task automatic go(input logic v);
    @(posedge aclk);
    start_cmd <= v;
  endtask
  // Ready seen at a falling edge still stands at the next rising edge
  task automatic wchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    forever begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
    chk(r, er);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a);
    chk(d, e);
    chk(r, er);
  endtask
  // Start with a given current; relays checked at lo and hi cycles
  task automatic run_to(input logic [15:0] cur, input int lo, input int hi);
    @(posedge aclk);
    motor_current <= cur;
    start_cmd <= 1'b1;
    cyc(1);
    chk(run_relay, 1'b0);
    cyc(1);
    chk({run_relay, at_speed_relay}, 2'b10);
    chk({scr_gate_en, thyristor_check_en, stack_overload_en}, 3'b000);
    cyc(lo - 2);
    chk({run_relay, at_speed_relay}, 2'b10);
    if (hi > 0) begin
      cyc(hi - lo);
      chk({run_relay, at_speed_relay}, 2'b11);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rchk(CTRL_OFS, 32'h0, 2'h0);
    rchk(AT_SPEED_OFS, 32'h2710, 2'h0);
    rchk(FB_TIME_OFS, 32'h1f4, 2'h0);
    rchk(RATED_CUR_OFS, 32'h64, 2'h0);
    rchk(8'h40, 32'h0, 2'h2);
    wchk(8'h40, 32'h1, 2'h2);
    wchk(AT_SPEED_OFS, 32'hffff0028, 2'h0);
    rchk(AT_SPEED_OFS, 32'h28, 2'h0);
    rchk(CTRL_OFS, 32'h0, 2'h0);
  endtask
  task automatic t_nowye();
    go(1'b1);
    cyc(6);
    chk(run_relay, 1'b0);
    chk(scr_gate_en, 1'b1);
    chk({thyristor_check_en, stack_overload_en}, 2'b11);
    go(1'b0);
  endtask
  // Open transition: feedback check off even with confirm set
  task automatic t_forced();
    wchk(CTRL_OFS, 32'h3, 2'h0);
    broken <= 1'b1;
    run_to(16'h0064, 155, 170);
    cyc(60);
    chk({run_relay, at_speed_relay, confirm_trip}, 3'b110);
    go(1'b0);
    cyc(2);
    chk({run_relay, at_speed_relay}, 2'b00);
  endtask
  task automatic t_early();
    wchk(CTRL_OFS, 32'h1, 2'h0);
    broken <= 1'b0;
    run_to(16'h0054, 40, 55);
    @(posedge aclk);
    fault_in <= 1'b1;
    cyc(2);
    chk({run_relay, at_speed_relay}, 2'b00);
    @(posedge aclk);
    fault_in <= 1'b0;
    start_cmd <= 1'b0;
    run_to(16'h0055, 95, 0);
    go(1'b0);
    cyc(2);
    chk(run_relay, 1'b0);
  endtask
  task automatic t_confirm();
    wchk(FB_TIME_OFS, 32'h5, 2'h0);
    wchk(CTRL_OFS, 32'h7, 2'h0);
    broken <= 1'b1;
    run_to(16'h0064, 155, 170);
    cyc(40);
    chk({run_relay, at_speed_relay, confirm_trip}, 3'b001);
    rd(STATUS_OFS);
    chk(d[5], 1'b1);
    cyc(10);
    chk(run_relay, 1'b0);
    go(1'b0);
    wchk(STATUS_OFS, 32'h20, 2'h0);
    broken <= 1'b0;
    dly <= 4'h6;
    cyc(1);
    chk(confirm_trip, 1'b0);
    run_to(16'h0064, 155, 170);
    cyc(40);
    chk({run_relay, at_speed_relay, confirm_trip, delta_close_feedback_input}, 4'hd);
    go(1'b0);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_nowye();
    t_forced();
    t_early();
    t_confirm();
    stop_test();
  end
  initial begin
    #50000;
    n_errors++;
    stop_test();
  end
endmodule
